// >>> aft_pkg.sv
// constants, types and register map of the acquisition trigger controller
// assumes a 10 MHz system clock and a plain strobe register port
package aft_pkg;

  // ----------------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CMD    = 8'h04;
  localparam logic [7:0] ADDR_FCOUNT = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0c;
  localparam logic [7:0] ADDR_EXPO   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ----------------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------------
  localparam int CFG_W         = 7;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT  = 1;
  localparam int ST_STATE_LSB  = 0;
  localparam int ST_COUNT_LSB  = 8;

  typedef struct packed {
    logic std_mode;
    logic rate_en;
    logic continuous;
    logic frame_ext;
    logic acq_falling;
    logic acq_line1;
    logic acq_trig_en;
  } aft_cfg_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_ACQ,
    ST_WAIT_FRAME,
    ST_EXPOSE
  } aft_state_type;

  // ----------------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [CFG_W-1:0] CTRL_RESET  = 7'h00;
  localparam logic [7:0]       FCOUNT_RESET = 8'h01;
  localparam logic [7:0]       FCOUNT_MIN   = 8'h01;
  localparam int               CLK_PERIOD_NS = 100;
  localparam int               EXPO_RESET_US = 100;
  localparam int               EXPO_RESET_CYC =
    (EXPO_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0]      EXPO_RESET   = 32'(EXPO_RESET_CYC);
  localparam logic [31:0]      PERIOD_RESET = 32'h0000_0000;

endpackage

// >>> aft_ctrl.sv
// acquisition and frame start trigger sequencer with its register port
// assumes inputs synchronous to clk except the external line, and a
// separate block that supplies the shortest legal frame period
//
// How it works
// - line 1 edge arms when acquisition trigger on
// - polarity bit picks rising or falling edge
// - waiting for acquisition ignores frame triggers
// - qualifying edge moves to waiting for frame
// - rearm once accepted frames equal frame count
// - each accepted frame trigger starts one frame
// - frame triggers ignored outside waiting for frame
// - internal frame triggers when external ones off
// - single mode: one internal frame per start
// - continuous mode: frames until stop command
// - rate control off: run at maximum rate
// - rate control on: run at programmed period
// - programmed rate above maximum is clamped
// - exposure length from programmed exposure time
// - comes up in legacy mode after reset
// - frame count accepts 1 through 255
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module aft_ctrl #(
  parameter int DATA_W = 32
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output var  logic [DATA_W-1:0] rd_data,
  input  wire logic              ext_acq_trigger_in,
  input  wire logic              frame_trigger_in,
  input  wire logic [31:0]       min_frame_period,
  output var  logic              frame_start,
  output var  logic              exposure_active,
  output var  logic              wait_acq_status,
  output var  logic              wait_frame_status
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------------
  // registers and commands
  // ----------------------------------------------------------------------
  aft_pkg::aft_cfg_type   cfg_reg;
  logic [7:0]             fcount_reg;
  logic [31:0]            period_reg;
  logic [31:0]            expo_reg;
  logic [DATA_W-1:0]      rd_data_reg;
  logic                   start_cmd;
  logic                   stop_cmd;

  assign start_cmd = wr_en && (addr == aft_pkg::ADDR_CMD)
                     && wr_data[aft_pkg::CMD_START_BIT];
  assign stop_cmd  = wr_en && (addr == aft_pkg::ADDR_CMD)
                     && wr_data[aft_pkg::CMD_STOP_BIT];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cfg_reg <= aft_pkg::aft_cfg_type'(aft_pkg::CTRL_RESET);
    else if (wr_en && addr == aft_pkg::ADDR_CTRL)
      cfg_reg <= aft_pkg::aft_cfg_type'(wr_data[aft_pkg::CFG_W-1:0]);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      fcount_reg <= aft_pkg::FCOUNT_RESET;
    else if (wr_en && addr == aft_pkg::ADDR_FCOUNT)
    begin
      if (wr_data[7:0] < aft_pkg::FCOUNT_MIN)
        fcount_reg <= aft_pkg::FCOUNT_MIN;
      else
        fcount_reg <= wr_data[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      period_reg <= aft_pkg::PERIOD_RESET;
      expo_reg   <= aft_pkg::EXPO_RESET;
    end
    else if (wr_en && addr == aft_pkg::ADDR_PERIOD)
      period_reg <= wr_data[31:0];
    else if (wr_en && addr == aft_pkg::ADDR_EXPO)
      expo_reg <= wr_data[31:0];
  end

  // ----------------------------------------------------------------------
  // external acquisition trigger line
  // ----------------------------------------------------------------------
  logic acq_meta_reg;
  logic acq_sync_reg;
  logic acq_prev_reg;
  logic acq_pulse_reg;
  logic acq_edge;

  // two-flop synchroniser, first stage read only by second
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      acq_meta_reg <= 1'b0;
      acq_sync_reg <= 1'b0;
      acq_prev_reg <= 1'b0;
    end
    else
    begin
      acq_meta_reg <= ext_acq_trigger_in;
      acq_sync_reg <= acq_meta_reg;
      acq_prev_reg <= acq_sync_reg;
    end
  end

  assign acq_edge = cfg_reg.acq_line1 &&
                    (cfg_reg.acq_falling ? (acq_prev_reg && !acq_sync_reg)
                                         : (!acq_prev_reg && acq_sync_reg));

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      acq_pulse_reg <= 1'b0;
    else
      acq_pulse_reg <= acq_edge;
  end

  acq_edge_rise_a: assert property (
    $rose(acq_sync_reg) && cfg_reg.acq_line1 && !cfg_reg.acq_falling
    |=> acq_pulse_reg)
    else $error("rising line edge gave no acquisition pulse");

  acq_pulse_one_a: assert property (
    acq_pulse_reg |=> !acq_pulse_reg)
    else $error("acquisition pulse longer than one cycle");

  // ----------------------------------------------------------------------
  // frame rate generator
  // ----------------------------------------------------------------------
  aft_pkg::aft_state_type state_reg;
  aft_pkg::aft_state_type state_next;
  logic [31:0]            elapsed_reg;
  logic [31:0]            eff_period;
  logic [31:0]            floor_period;
  logic                   frame_fire;
  logic                   int_ready;

  // a zero minimum would fire every cycle; keep at least one
  assign floor_period = (min_frame_period == 32'h0) ? 32'h1
                                                    : min_frame_period;

  assign eff_period = (cfg_reg.rate_en && period_reg > floor_period)
                      ? period_reg : floor_period;

  assign int_ready = (elapsed_reg >= eff_period);

  assign frame_fire = (state_reg == aft_pkg::ST_WAIT_FRAME) && !stop_cmd
                      && !start_cmd
                      && (cfg_reg.frame_ext ? frame_trigger_in : int_ready);

  // saturating, so the first frame after a start fires at once
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      elapsed_reg <= 32'h0;
    else if (start_cmd)
      elapsed_reg <= 32'hffff_ffff;
    else if (frame_fire)
      elapsed_reg <= 32'h1;
    else if (elapsed_reg != 32'hffff_ffff)
      elapsed_reg <= elapsed_reg + 32'h1;
  end

  int_rate_a: assert property (
    state_reg == aft_pkg::ST_WAIT_FRAME && !cfg_reg.frame_ext
    && int_ready && !stop_cmd && !start_cmd |-> frame_fire)
    else $error("internal trigger late");

  int_clamp_a: assert property (
    frame_fire && !cfg_reg.frame_ext
    |-> elapsed_reg >= floor_period
        && (!cfg_reg.rate_en || elapsed_reg >= period_reg))
    else $error("internal trigger faster than allowed");

  // ----------------------------------------------------------------------
  // frame counter and exposure
  // ----------------------------------------------------------------------
  logic [7:0]  frame_cnt_reg;
  logic [31:0] expo_left_reg;
  logic [31:0] expo_eff;
  logic        expo_done;
  logic        frames_done;

  assign expo_eff    = (expo_reg == 32'h0) ? 32'h1 : expo_reg;
  assign expo_done   = (state_reg == aft_pkg::ST_EXPOSE)
                       && (expo_left_reg == 32'h1);
  assign frames_done = (frame_cnt_reg == fcount_reg);

  always_ff @(posedge clk)
  begin
    if (sys_rst || stop_cmd || start_cmd)
      frame_cnt_reg <= 8'h0;
    else if (state_reg == aft_pkg::ST_WAIT_ACQ && acq_pulse_reg)
      frame_cnt_reg <= 8'h0;
    else if (frame_fire)
      frame_cnt_reg <= frame_cnt_reg + 8'h1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || stop_cmd || start_cmd)
      expo_left_reg <= 32'h0;
    else if (frame_fire)
      expo_left_reg <= expo_eff;
    else if (expo_left_reg != 32'h0)
      expo_left_reg <= expo_left_reg - 32'h1;
  end

  expo_len_a: assert property (
    frame_fire |=> expo_left_reg == $past(expo_eff))
    else $error("exposure not loaded from exposure time");

  // ----------------------------------------------------------------------
  // acquisition state machine
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    if (stop_cmd)
      state_next = aft_pkg::ST_IDLE;
    else if (start_cmd)
    begin
      if (cfg_reg.std_mode)
      begin
        if (cfg_reg.acq_trig_en)
          state_next = aft_pkg::ST_WAIT_ACQ;
        else
          state_next = aft_pkg::ST_WAIT_FRAME;
      end
    end
    else
    begin
      case (state_reg)
        aft_pkg::ST_WAIT_ACQ:
          if (acq_pulse_reg)
            state_next = aft_pkg::ST_WAIT_FRAME;
        aft_pkg::ST_WAIT_FRAME:
          if (frame_fire)
            state_next = aft_pkg::ST_EXPOSE;
        aft_pkg::ST_EXPOSE:
          if (expo_done)
          begin
            // rearm after the last counted frame
            if (cfg_reg.acq_trig_en && frames_done)
              state_next = aft_pkg::ST_WAIT_ACQ;
            // host keeps continuous with acquisition trigger
            else if (!cfg_reg.frame_ext && !cfg_reg.continuous)
              state_next = aft_pkg::ST_IDLE;
            else
              state_next = aft_pkg::ST_WAIT_FRAME;
          end
        default:
          state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_reg <= aft_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  wait_acq_ignore_a: assert property (
    state_reg == aft_pkg::ST_WAIT_ACQ |-> !frame_fire)
    else $error("frame trigger taken while waiting for acquisition");

  arm_on_edge_a: assert property (
    state_reg == aft_pkg::ST_WAIT_ACQ && acq_pulse_reg
    && !stop_cmd && !start_cmd |=> state_reg == aft_pkg::ST_WAIT_FRAME)
    else $error("acquisition edge did not arm");

  count_rearm_a: assert property (
    expo_done && cfg_reg.acq_trig_en && frames_done
    && !stop_cmd && !start_cmd |=> state_reg == aft_pkg::ST_WAIT_ACQ)
    else $error("no rearm after last frame");

  single_once_a: assert property (
    expo_done && !cfg_reg.acq_trig_en && !cfg_reg.frame_ext
    && !cfg_reg.continuous && !stop_cmd && !start_cmd
    |=> state_reg == aft_pkg::ST_IDLE ##1 !frame_start)
    else $error("single frame mode made more than one frame");

  cont_runs_a: assert property (
    expo_done && !cfg_reg.acq_trig_en && cfg_reg.continuous
    && !stop_cmd && !start_cmd |=> state_reg == aft_pkg::ST_WAIT_FRAME)
    else $error("continuous mode stopped without stop command");

  stop_idle_a: assert property (
    stop_cmd |=> state_reg == aft_pkg::ST_IDLE && frame_cnt_reg == 8'h0
    && !exposure_active ##1 !frame_start)
    else $error("stop did not return to idle");

  legacy_hold_a: assert property (
    !cfg_reg.std_mode && state_reg == aft_pkg::ST_IDLE
    |=> state_reg == aft_pkg::ST_IDLE)
    else $error("left idle in legacy mode");

  fcount_range_a: assert property (
    fcount_reg != 8'h0)
    else $error("frame count out of range");

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  logic frame_start_reg;
  logic exposure_active_reg;
  logic wait_acq_reg;
  logic wait_frame_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      frame_start_reg     <= 1'b0;
      exposure_active_reg <= 1'b0;
      wait_acq_reg        <= 1'b0;
      wait_frame_reg      <= 1'b0;
    end
    else
    begin
      frame_start_reg     <= frame_fire;
      exposure_active_reg <= (state_next == aft_pkg::ST_EXPOSE);
      wait_acq_reg        <= (state_next == aft_pkg::ST_WAIT_ACQ);
      wait_frame_reg      <= (state_next == aft_pkg::ST_WAIT_FRAME);
    end
  end

  assign frame_start       = frame_start_reg;
  assign exposure_active   = exposure_active_reg;
  assign wait_acq_status   = wait_acq_reg;
  assign wait_frame_status = wait_frame_reg;

  frame_start_a: assert property (
    frame_fire |=> frame_start && exposure_active)
    else $error("accepted trigger did not start a frame");

  not_waiting_a: assert property (
    state_reg != aft_pkg::ST_WAIT_FRAME |=> !frame_start)
    else $error("frame started outside waiting for frame");

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || !rd_en)
      rd_data_reg <= '0;
    else if (addr == aft_pkg::ADDR_CTRL)
      rd_data_reg <= DATA_W'(cfg_reg);
    else if (addr == aft_pkg::ADDR_FCOUNT)
      rd_data_reg <= DATA_W'(fcount_reg);
    else if (addr == aft_pkg::ADDR_PERIOD)
      rd_data_reg <= DATA_W'(period_reg);
    else if (addr == aft_pkg::ADDR_EXPO)
      rd_data_reg <= DATA_W'(expo_reg);
    else if (addr == aft_pkg::ADDR_STATUS)
      rd_data_reg <= DATA_W'({frame_cnt_reg, 6'h0, 2'(state_reg)});
    else
      rd_data_reg <= '0;
  end

  assign rd_data = rd_data_reg;

  arm_c: cover property (
    state_reg == aft_pkg::ST_WAIT_ACQ ##1
    state_reg == aft_pkg::ST_WAIT_FRAME);
  rearm_c: cover property (
    expo_done && cfg_reg.acq_trig_en && frames_done ##1
    state_reg == aft_pkg::ST_WAIT_ACQ);
  single_c: cover property (
    frame_start && !cfg_reg.continuous && !cfg_reg.frame_ext);
  clamp_c: cover property (
    frame_fire && cfg_reg.rate_en && period_reg < floor_period);

endmodule

`default_nettype wire

// >>> aft_trig_src.sv
// far-side model: external acquisition line and frame trigger source
// assumes the bench calls its tasks and shares the system clock
`timescale 1ns/10ps
`default_nettype none

module aft_trig_src (
  input  wire logic clk,
  output var  logic ext_acq_trigger_in,
  output var  logic frame_trigger_in
);

  // --------------------------------------------------------------------
  // idle levels
  // --------------------------------------------------------------------
  initial
  begin
    ext_acq_trigger_in = 1'b0;
    frame_trigger_in   = 1'b0;
  end

  // --------------------------------------------------------------------
  // stimulus tasks
  // --------------------------------------------------------------------
  // line moves after dly+1 cycles, so both prompt and slow edges occur
  task automatic set_line(input logic lvl, input int dly);
    repeat (dly) @(posedge clk);
    @(posedge clk);
    ext_acq_trigger_in <= lvl;
  endtask

  // one-cycle pulse on the clock, back to low at once
  task automatic pulse_frame(input int dly);
    repeat (dly) @(posedge clk);
    @(posedge clk);
    frame_trigger_in <= 1'b1;
    @(posedge clk);
    frame_trigger_in <= 1'b0;
  endtask

endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the acquisition and frame trigger sequencer
// assumes aft_pkg, aft_ctrl and the aft_trig_src model are compiled first
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [31:0] ST  = 32'h0000_ff03;

  logic        clk              = 1'b0;
  logic        sys_rst          = 1'b1;
  logic [7:0]  addr             = 8'h00;
  logic [31:0] wr_data          = 32'h0000_0000;
  logic        wr_en            = 1'b0;
  logic        rd_en            = 1'b0;
  logic [31:0] min_frame_period = 32'h0000_0008;
  logic [31:0] rd_data;
  logic        ext_acq_trigger_in;
  logic        frame_trigger_in;
  logic        frame_start;
  logic        exposure_active;
  logic        wait_acq_status;
  logic        wait_frame_status;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          seed         = 2840;
  int          n_frames     = 0;
  int          cyc          = 0;
  int          last_fs      = 0;
  int          exp_len      = 0;
  int          expo_cyc     = 1000;
  int          g;
  logic        rd_pend      = 1'b0;
  logic [31:0] rd_exp[$];
  logic [31:0] rd_msk[$];
  int          gap_q[$];

  always #50 clk = ~clk;

  aft_ctrl #(.DATA_W(32)) i_aft_ctrl (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .addr              (addr),
    .wr_data           (wr_data),
    .wr_en             (wr_en),
    .rd_en             (rd_en),
    .rd_data           (rd_data),
    .ext_acq_trigger_in(ext_acq_trigger_in),
    .frame_trigger_in  (frame_trigger_in),
    .min_frame_period  (min_frame_period),
    .frame_start       (frame_start),
    .exposure_active   (exposure_active),
    .wait_acq_status   (wait_acq_status),
    .wait_frame_status (wait_frame_status)
  );

  aft_trig_src i_aft_trig_src (
    .clk               (clk),
    .ext_acq_trigger_in(ext_acq_trigger_in),
    .frame_trigger_in  (frame_trigger_in)
  );

  // --------------------------------------------------------------------
  // compare and report
  // --------------------------------------------------------------------
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp,
                        input logic [31:0] msk);
    total_checks++;
    if ((got & msk) !== (exp & msk))
    begin
      n_mismatch++;
      $display("unexpected read at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("unexpected count at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tend(input string name);
    $display("test %s done, mismatches %0d", name, n_mismatch);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // register port master
  // --------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    rd_exp.push_back(e);
    rd_msk.push_back(m);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait on the frame counter of the watcher
  task automatic wait_to(input int t);
    int k;
    for (k = 0; k < 3000 && n_frames < t; k++)
      @(posedge clk);
    if (n_frames < t)
    begin
      n_mismatch++;
      conclude();
    end
  endtask

  // --------------------------------------------------------------------
  // watcher: read data, frame spacing, exposure length
  // --------------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (rd_pend)
      chk_rd(rd_data, rd_exp.pop_front(), rd_msk.pop_front());
    rd_pend = rd_en;
    if (frame_start === 1'b1)
    begin
      n_frames++;
      // an unannounced frame gets -2, which no real gap can match
      g = (gap_q.size() > 0) ? gap_q.pop_front() : -2;
      if (g != -1)
        chk_cnt(cyc - last_fs, g);
      last_fs = cyc;
    end
    if (exposure_active === 1'b1)
      exp_len++;
    else if (exp_len > 0)
    begin
      chk_cnt(exp_len, expo_cyc);
      exp_len = 0;
    end
  end

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial
  begin
    int   t;
    int   p;
    int   per[4];
    int   gaps[4];
    logic a;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(aft_pkg::ADDR_CTRL, 32'(aft_pkg::CTRL_RESET), ALL);
    rd(aft_pkg::ADDR_FCOUNT, 32'(aft_pkg::FCOUNT_RESET), ALL);
    rd(aft_pkg::ADDR_PERIOD, aft_pkg::PERIOD_RESET, ALL);
    rd(aft_pkg::ADDR_EXPO, aft_pkg::EXPO_RESET, ALL);
    rd(8'h18, 32'h0000_0000, ALL);
    rd(aft_pkg::ADDR_CMD, 32'h0000_0000, ALL);
    wr(aft_pkg::ADDR_CMD, 32'h0000_0001);
    idle(4);
    rd(aft_pkg::ADDR_STATUS, 32'h0000_0000, ALL);
    wr(aft_pkg::ADDR_FCOUNT, 32'h0000_0000);
    rd(aft_pkg::ADDR_FCOUNT, 32'h0000_0001, ALL);
    wr(aft_pkg::ADDR_FCOUNT, 32'h0000_00ff);
    rd(aft_pkg::ADDR_FCOUNT, 32'h0000_00ff, ALL);
    tend("registers");

    wr(aft_pkg::ADDR_CTRL, 32'h0000_0040);
    wr(aft_pkg::ADDR_EXPO, 32'h0000_0003);
    expo_cyc = 3;
    repeat (2)
    begin
      gap_q.push_back(-1);
      t = n_frames + 1;
      wr(aft_pkg::ADDR_CMD, 32'h0000_0001);
      wait_to(t);
    end
    idle(40);
    chk_cnt(gap_q.size(), 0);
    rd(aft_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0003);
    tend("single");

    p    = 12 + ($random(seed) & 15);
    per  = '{p, 5, 20, 8};
    gaps = '{p, 6, 8, 8};
    for (int i = 0; i < 4; i++)
    begin
      // third case has rate control off, so its period is not used
      wr(aft_pkg::ADDR_CTRL, (i == 2) ? 32'h0000_0050 : 32'h0000_0070);
      wr(aft_pkg::ADDR_PERIOD, 32'(per[i]));
      // a moving maximum rate, so the clamp follows the live limit
      min_frame_period <= (i == 1) ? 32'h0000_0006 : 32'h0000_0008;
      gap_q.push_back(-1);
      repeat (3) gap_q.push_back(gaps[i]);
      t = n_frames + 4;
      wr(aft_pkg::ADDR_CMD, 32'h0000_0001);
      wait_to(t);
      wr(aft_pkg::ADDR_CMD, 32'h0000_0002);
      idle(40);
      chk_cnt(gap_q.size(), 0);
      rd(aft_pkg::ADDR_STATUS, 32'h0000_0000, ST);
    end
    tend("continuous");

    for (int f = 0; f < 2; f++)
    begin
      a = (f == 0);
      i_aft_trig_src.set_line(a, 0);
      wr(aft_pkg::ADDR_FCOUNT, 32'h0000_0002);
      wr(aft_pkg::ADDR_CTRL, 32'h0000_005b | 32'(f << 2));
      wr(aft_pkg::ADDR_CMD, 32'h0000_0001);
      idle(8);
      rd(aft_pkg::ADDR_STATUS, 32'h0000_0001, ST);
      i_aft_trig_src.pulse_frame(0);
      i_aft_trig_src.set_line(!a, 2);
      idle(8);
      rd(aft_pkg::ADDR_STATUS, 32'h0000_0001, ST);
      i_aft_trig_src.set_line(a, 3);
      idle(8);
      rd(aft_pkg::ADDR_STATUS, 32'h0000_0002, ST);
      gap_q.push_back(-1);
      i_aft_trig_src.pulse_frame(0);
      i_aft_trig_src.pulse_frame(1);
      idle(10);
      rd(aft_pkg::ADDR_STATUS, 32'h0000_0102, ST);
      gap_q.push_back(-1);
      i_aft_trig_src.pulse_frame(2);
      idle(10);
      rd(aft_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0003);
      i_aft_trig_src.pulse_frame(0);
      idle(10);
      chk_cnt(gap_q.size(), 0);
      wr(aft_pkg::ADDR_CMD, 32'h0000_0002);
      idle(2);
      rd(aft_pkg::ADDR_STATUS, 32'h0000_0000, ST);
    end
    tend("acquisition");
    idle(4);
    conclude();
  end

endmodule
`default_nettype wire
